// >>> bcc_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the chip-control upper half
// Assumes: 125 MHz system clock
// Notes: definitions only
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH
`define BCC_OFF_CHIP_CTRL 8'h40
`define BCC_B_FC_ONE 15
`define BCC_B_RETRY_STS 16
`define BCC_F_RETRY_LO 17
`define BCC_B_DISC_DIS 19
`define BCC_B_DISC_SHORT 20
`define BCC_F_CRS_LO 21
`define BCC_B_DT_ORDER 23
`define BCC_F_CPL_LO 24
`define BCC_B_ISO_EN 26
`define BCC_F_TC_LO 27
`define BCC_B_LOOPBACK 30
`define BCC_B_LOCKOUT 31
`define BCC_RST_CRS 2'h1
`define BCC_RST_CPL 2'h1
`define BCC_RST_TC 3'h1
`define BCC_RETRY_256 32'h0000_0100
`define BCC_RETRY_64K 32'h0001_0000
`define BCC_RETRY_2G 32'h8000_0000
`define BCC_DISC_SHORT_CLKS 16'h0040
`define BCC_DISC_LONG_CLKS 16'h8000
`define BCC_DISC_NORM_CLKS 16'h0400
`define BCC_CLK_MHZ 125
`define BCC_CRS_US0 25
`define BCC_CRS_US1 500
`define BCC_CRS_US2 5000
`define BCC_CRS_US3 25000
`define BCC_CPL_US0 50
`define BCC_CPL_US1 1000
`define BCC_CPL_US2 10000
`define BCC_CPL_US3 50000
`endif

// >>> bcc_pkg.sv
// Purpose: types of the chip-control block
// Assumes: nothing
// Notes: constants live in bcc_map.svh
package bcc_pkg;
  typedef enum logic [1:0] {
    BCC_TMR_IDLE = 2'b01,
    BCC_TMR_RUN = 2'b10
  } bcc_tmr_e;
  typedef logic [31:0] bcc_word_t;
endpackage

// >>> bcc_timer.sv
// Purpose: one-shot cycle timer with expiry pulse
// Assumes: limit stable while running
// Notes: used for retry, discard, config-retry and completion timing
`timescale 1ns/100ps
module bcc_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic stop,
  input wire logic [W-1:0] limit,
  // result
  output logic expired
);
  bcc_pkg::bcc_tmr_e state_reg;
  logic [W-1:0] count_reg;
  wire logic hit = (state_reg == bcc_pkg::BCC_TMR_RUN) && tick && (count_reg + W'(1) >= limit);
  always_ff @(posedge clk) begin
    if (!reset_n || stop) begin
      state_reg <= bcc_pkg::BCC_TMR_IDLE;
      count_reg <= '0;
    end else if (start) begin
      state_reg <= bcc_pkg::BCC_TMR_RUN;
      count_reg <= '0;
    end else if (hit) begin
      state_reg <= bcc_pkg::BCC_TMR_IDLE;
    end else if (state_reg == bcc_pkg::BCC_TMR_RUN && tick) begin
      count_reg <= count_reg + W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      expired <= 1'b0;
    end else begin
      expired <= hit && !stop && !start;
    end
  end
endmodule // bcc_timer

// >>> bcc_chip_ctrl.sv
// Purpose: upper half of the bridge chip-control register and the behaviour it steers
// Assumes: config access port is synchronous, one-cycle strobes, straps stable around reset
// Notes: the retry limit 00 never expires
//
// Behaviour
// - bit 15 low gives a credit update every two free credits, high every single one.
// - status bit 16 sets on retry expiry and stays set until a one is written to it.
// - bits 18:17 choose no limit, 256, 64K or 2G retries before expiry.
// - bit 19 disables the discard timer, and bridge-control bit 27 disables it on its own as well.
// - bit 20 makes the discard timer expire after 64 PCI clocks.
// - with bit 20 clear the length follows bridge-control bit 24 forward or 25 reverse.
// - bits 22:21 set the config retry timer to 25us, 0.5ms, 5ms or 25ms, reset 01.
// - bits 25:24 set the completion timer to 50us, 1ms, 10ms or 50ms, reset 01.
// - bit 23 high keeps delayed transactions strictly in order.
// - bit 26 low maps PCI-X memory traffic to class 0, high to the programmed class.
// - bits 29:27 hold the isochronous class, read-write, reset 001.
// - bit 30 loops serial transmit to receive only with straps low-high-high, mask and reverse high.
// - in forward operation the loopback bit is read-only at zero.
// - bit 31 set refuses primary config access with CRS forward or retry reverse.
// - bit 31 resets to one when the first test strap is high.
`timescale 1ns/100ps
`include "bcc_map.svh"
module bcc_chip_ctrl #(
  parameter int CRS_US0 = `BCC_CRS_US0,
  parameter int CRS_US1 = `BCC_CRS_US1,
  parameter int CRS_US2 = `BCC_CRS_US2,
  parameter int CRS_US3 = `BCC_CRS_US3,
  parameter int CPL_US0 = `BCC_CPL_US0,
  parameter int CPL_US1 = `BCC_CPL_US1,
  parameter int CPL_US2 = `BCC_CPL_US2,
  parameter int CPL_US3 = `BCC_CPL_US3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // straps
  input wire logic test_strap_zero,
  input wire logic test_strap_one,
  input wire logic test_strap_two,
  input wire logic mask_strap_input,
  input wire logic direction_strap,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_from_primary,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_accept,
  output logic cfg_crs,
  output logic cfg_target_retry,
  // bridge control bits from offset 3Ch
  input wire logic bctl_disc_dis,
  input wire logic bctl_prim_disc_long,
  input wire logic bctl_sec_disc_long,
  // flow control
  input wire logic credit_freed,
  output logic fc_update,
  // retry and discard
  input wire logic pci_retry,
  input wire logic pci_retry_done,
  input wire logic disc_start,
  input wire logic disc_stop,
  output logic disc_expired,
  // timeouts
  input wire logic crs_start,
  input wire logic crs_stop,
  output logic crs_expired,
  input wire logic cpl_start,
  input wire logic cpl_stop,
  output logic cpl_expired,
  // traffic mapping and modes
  output logic [2:0] tx_traffic_class,
  output logic dt_in_order,
  output logic loopback_active
);
  // ============================================================
  // register fields
  bcc_pkg::bcc_word_t ctrl_word;
  logic fc_one_reg, retry_sts_reg, disc_dis_reg, disc_short_reg, dt_order_reg;
  logic iso_en_reg, loop_reg, lockout_reg, first_reg;
  logic [1:0] retry_lim_reg, crs_sel_reg, cpl_sel_reg;
  logic [2:0] tc_reg;
  wire logic forward = !direction_strap;
  wire logic hit = (cfg_addr == `BCC_OFF_CHIP_CTRL);
  wire logic locked = lockout_reg && cfg_from_primary;
  wire logic do_wr = cfg_wr && hit && !locked;
  wire logic wr_b1 = do_wr && cfg_be[1];
  wire logic wr_b2 = do_wr && cfg_be[2];
  wire logic wr_b3 = do_wr && cfg_be[3];
  wire logic retry_exp;
  wire logic loop_ok = !test_strap_zero && test_strap_one && test_strap_two
    && mask_strap_input && direction_strap;
  // ============================================================
  // register writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fc_one_reg <= 1'b0;
      retry_lim_reg <= 2'h0;
      disc_dis_reg <= 1'b0;
      disc_short_reg <= 1'b0;
      crs_sel_reg <= `BCC_RST_CRS;
      dt_order_reg <= 1'b0;
      cpl_sel_reg <= `BCC_RST_CPL;
      iso_en_reg <= 1'b0;
      tc_reg <= `BCC_RST_TC;
      loop_reg <= 1'b0;
    end else begin
      if (wr_b1) fc_one_reg <= cfg_wdata[`BCC_B_FC_ONE];
      if (wr_b2) begin
        retry_lim_reg <= cfg_wdata[`BCC_F_RETRY_LO +: 2];
        disc_dis_reg <= cfg_wdata[`BCC_B_DISC_DIS];
        disc_short_reg <= cfg_wdata[`BCC_B_DISC_SHORT];
        crs_sel_reg <= cfg_wdata[`BCC_F_CRS_LO +: 2];
        dt_order_reg <= cfg_wdata[`BCC_B_DT_ORDER];
      end
      if (wr_b3) begin
        cpl_sel_reg <= cfg_wdata[`BCC_F_CPL_LO +: 2];
        iso_en_reg <= cfg_wdata[`BCC_B_ISO_EN];
        tc_reg <= cfg_wdata[`BCC_F_TC_LO +: 3];
        if (!forward) loop_reg <= cfg_wdata[`BCC_B_LOOPBACK];
      end
    end
  end
  // ============================================================
  // sticky status and strap-loaded lockout
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      retry_sts_reg <= 1'b0;
      lockout_reg <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
      if (retry_exp) retry_sts_reg <= 1'b1;
      else if (wr_b2 && cfg_wdata[`BCC_B_RETRY_STS]) retry_sts_reg <= 1'b0;
      if (first_reg) lockout_reg <= test_strap_zero;
      else if (wr_b3) lockout_reg <= cfg_wdata[`BCC_B_LOCKOUT];
    end
  end
  // ============================================================
  // read path and config answer
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`BCC_B_FC_ONE] = fc_one_reg;
    ctrl_word[`BCC_B_RETRY_STS] = retry_sts_reg;
    ctrl_word[`BCC_F_RETRY_LO +: 2] = retry_lim_reg;
    ctrl_word[`BCC_B_DISC_DIS] = disc_dis_reg;
    ctrl_word[`BCC_B_DISC_SHORT] = disc_short_reg;
    ctrl_word[`BCC_F_CRS_LO +: 2] = crs_sel_reg;
    ctrl_word[`BCC_B_DT_ORDER] = dt_order_reg;
    ctrl_word[`BCC_F_CPL_LO +: 2] = cpl_sel_reg;
    ctrl_word[`BCC_B_ISO_EN] = iso_en_reg;
    ctrl_word[`BCC_F_TC_LO +: 3] = tc_reg;
    ctrl_word[`BCC_B_LOOPBACK] = loop_reg;
    ctrl_word[`BCC_B_LOCKOUT] = lockout_reg;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_rdata <= '0;
      cfg_accept <= 1'b0;
      cfg_crs <= 1'b0;
      cfg_target_retry <= 1'b0;
    end else begin
      cfg_rdata <= (cfg_rd && hit && !locked) ? ctrl_word : 32'h0000_0000;
      cfg_accept <= (cfg_rd || cfg_wr) && !locked;
      cfg_crs <= (cfg_rd || cfg_wr) && locked && forward;
      cfg_target_retry <= (cfg_rd || cfg_wr) && locked && !forward;
    end
  end
  // ============================================================
  // flow control credit update
  logic credit_half_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      credit_half_reg <= 1'b0;
      fc_update <= 1'b0;
    end else begin
      fc_update <= credit_freed && (fc_one_reg || credit_half_reg);
      if (credit_freed) credit_half_reg <= fc_one_reg ? 1'b0 : !credit_half_reg;
    end
  end
  // ============================================================
  // timers
  // the first retry only starts the timer, so the count stops one short of the limit
  wire logic [31:0] retry_lim = ((retry_lim_reg == 2'h1) ? `BCC_RETRY_256
    : (retry_lim_reg == 2'h2) ? `BCC_RETRY_64K : `BCC_RETRY_2G) - 32'h0000_0001;
  wire logic bctl_long = forward ? bctl_prim_disc_long : bctl_sec_disc_long;
  wire logic [15:0] disc_lim = disc_short_reg ? `BCC_DISC_SHORT_CLKS
    : bctl_long ? `BCC_DISC_LONG_CLKS : `BCC_DISC_NORM_CLKS;
  wire logic disc_off = disc_dis_reg || bctl_disc_dis;
  localparam int CRS_C0 = CRS_US0 * `BCC_CLK_MHZ;
  localparam int CRS_C1 = CRS_US1 * `BCC_CLK_MHZ;
  localparam int CRS_C2 = CRS_US2 * `BCC_CLK_MHZ;
  localparam int CRS_C3 = CRS_US3 * `BCC_CLK_MHZ;
  localparam int CPL_C0 = CPL_US0 * `BCC_CLK_MHZ;
  localparam int CPL_C1 = CPL_US1 * `BCC_CLK_MHZ;
  localparam int CPL_C2 = CPL_US2 * `BCC_CLK_MHZ;
  localparam int CPL_C3 = CPL_US3 * `BCC_CLK_MHZ;
  wire logic [31:0] crs_lim = (crs_sel_reg == 2'h0) ? 32'(CRS_C0)
    : (crs_sel_reg == 2'h1) ? 32'(CRS_C1)
    : (crs_sel_reg == 2'h2) ? 32'(CRS_C2) : 32'(CRS_C3);
  wire logic [31:0] cpl_lim = (cpl_sel_reg == 2'h0) ? 32'(CPL_C0)
    : (cpl_sel_reg == 2'h1) ? 32'(CPL_C1)
    : (cpl_sel_reg == 2'h2) ? 32'(CPL_C2) : 32'(CPL_C3);
  logic retry_run_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) retry_run_reg <= 1'b0;
    else retry_run_reg <= (retry_run_reg || pci_retry) && !pci_retry_done && !retry_exp;
  end
  bcc_timer #(.W(32)) u_retry (
    .clk(clk), .reset_n(reset_n),
    .start(pci_retry && !retry_run_reg && retry_lim_reg != 2'h0),
    .tick(pci_retry), .stop(pci_retry_done || retry_lim_reg == 2'h0),
    .limit(retry_lim), .expired(retry_exp)
  );
  bcc_timer #(.W(16)) u_disc (
    .clk(clk), .reset_n(reset_n), .start(disc_start && !disc_off), .tick(1'b1),
    .stop(disc_stop || disc_off), .limit(disc_lim), .expired(disc_expired)
  );
  bcc_timer #(.W(32)) u_crs (
    .clk(clk), .reset_n(reset_n), .start(crs_start), .tick(1'b1),
    .stop(crs_stop), .limit(crs_lim), .expired(crs_expired)
  );
  bcc_timer #(.W(32)) u_cpl (
    .clk(clk), .reset_n(reset_n), .start(cpl_start), .tick(1'b1),
    .stop(cpl_stop), .limit(cpl_lim), .expired(cpl_expired)
  );
  // ============================================================
  // mode outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_traffic_class <= 3'h0;
      dt_in_order <= 1'b0;
      loopback_active <= 1'b0;
    end else begin
      tx_traffic_class <= iso_en_reg ? tc_reg : 3'h0;
      dt_in_order <= dt_order_reg;
      loopback_active <= loop_reg && loop_ok;
    end
  end
  // ============================================================
  // checks
  AST_STS_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
    retry_exp |=> retry_sts_reg) else $error("status not set");
  AST_STS_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    retry_sts_reg && !(wr_b2 && cfg_wdata[16]) |=> retry_sts_reg) else $error("status lost");
  AST_TC: assert property (@(posedge clk) disable iff (!reset_n)
    !iso_en_reg |=> tx_traffic_class == 3'h0) else $error("class not zero");
  AST_LOOP_FWD: assert property (@(posedge clk) disable iff (!reset_n)
    forward && !loop_reg |=> !loop_reg) else $error("loopback written forward");
  AST_LOOP: assert property (@(posedge clk) disable iff (!reset_n)
    !loop_ok |=> !loopback_active) else $error("loopback without straps");
  AST_LOCK: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg_rd || cfg_wr) && locked && forward |=> cfg_crs && !cfg_accept) else $error("no crs");
  AST_LOCK_REV: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg_rd || cfg_wr) && locked && !forward |=> cfg_target_retry && !cfg_accept)
    else $error("no target retry");
  AST_FC: assert property (@(posedge clk) disable iff (!reset_n)
    credit_freed && fc_one_reg |=> fc_update) else $error("no credit update");
  AST_DISC_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    disc_off |=> !disc_expired) else $error("discard while off");
  AST_ORDER: assert property (@(posedge clk) disable iff (!reset_n)
    dt_order_reg |=> dt_in_order) else $error("order not kept");
  COV_RETRY: cover property (@(posedge clk) retry_exp);
  COV_CRS: cover property (@(posedge clk) cfg_crs);
  COV_LOOP: cover property (@(posedge clk) loopback_active);
endmodule // bcc_chip_ctrl

// >>> bcc_far_model.sv
// Purpose: far-side agent that frees credits and retries pci transactions
// Assumes: bench clock, events change at the falling edge
// Notes: behavioural, credit gap set by the caller, retries one every second clock
`timescale 1ns/100ps
module bcc_far_model (
  // clock
  input wire logic clk,
  // events
  output logic credit_freed,
  output logic pci_retry,
  output logic pci_retry_done
);
  // ====================
  // event tasks
  initial begin
    credit_freed = 1'b0;
    pci_retry = 1'b0;
    pci_retry_done = 1'b0;
  end
  task automatic credits(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) credit_freed = 1'b1;
      @(negedge clk) credit_freed = 1'b0;
      repeat (gap) @(negedge clk);
    end
  endtask
  task automatic retries(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) pci_retry = 1'b1;
      @(negedge clk) pci_retry = 1'b0;
    end
    @(negedge clk) pci_retry_done = 1'b1;
    @(negedge clk) pci_retry_done = 1'b0;
  endtask
endmodule // bcc_far_model

// >>> tb_bcc_chip_ctrl.sv
// Purpose: self-checking bench of the chip-control upper half
// Assumes: shortened timer parameters, far side from bcc_far_model
// Notes: seed fixed, inputs driven at the falling edge
`timescale 1ns/100ps
`include "bcc_map.svh"
module tb_bcc_chip_ctrl;
  localparam logic [31:0] M = 32'hFFFF_8000;
  logic clk, reset_n, tz, t1, t2, msk, dir, wr, rd, prim, acc_ok, crs, tret, dd, pl, sl;
  logic credit_freed, fc_update, pci_retry, pci_retry_done, dt_in_order, loopback_active;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdata, mdl, got;
  logic [2:0] tx_traffic_class, rsp, st, sp;
  wire [2:0] ex;
  int error_cnt, total_checks, fc_cnt, cyc, n, seed;
  // ====================
  // design and far side
  bcc_chip_ctrl #(.CRS_US0(1), .CRS_US1(2), .CRS_US2(3), .CRS_US3(4),
    .CPL_US0(5), .CPL_US1(6), .CPL_US2(7), .CPL_US3(8)) u_bcc_chip_ctrl (
    .clk, .reset_n, .test_strap_zero(tz), .test_strap_one(t1), .test_strap_two(t2),
    .mask_strap_input(msk), .direction_strap(dir), .cfg_wr(wr), .cfg_rd(rd),
    .cfg_from_primary(prim), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd),
    .cfg_rdata(rdata), .cfg_accept(acc_ok), .cfg_crs(crs), .cfg_target_retry(tret),
    .bctl_disc_dis(dd), .bctl_prim_disc_long(pl), .bctl_sec_disc_long(sl),
    .credit_freed, .fc_update, .pci_retry, .pci_retry_done, .disc_start(st[0]),
    .disc_stop(sp[0]), .disc_expired(ex[0]), .crs_start(st[1]), .crs_stop(sp[1]),
    .crs_expired(ex[1]), .cpl_start(st[2]), .cpl_stop(sp[2]), .cpl_expired(ex[2]),
    .tx_traffic_class, .dt_in_order, .loopback_active);
  bcc_far_model u_bcc_far_model (.clk, .credit_freed, .pci_retry, .pci_retry_done);
  always #4 clk = ~clk;
  always @(posedge clk) if (fc_update) fc_cnt++;
  // ====================
  // checks and model
  function automatic logic [31:0] nx(logic [31:0] o, d, logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'hFFFE_8000;
    m[30] = m[30] & dir;
    nx = (o & ~m) | (d & m);
    if (b[2] && d[16]) nx[16] = 1'b0;
  endfunction
  task automatic chk(logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkr(int g, lo, hi);
    total_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ====================
  // access tasks
  task automatic acc(logic w, p, logic [31:0] d, logic [3:0] b);
    @(negedge clk);
    {wr, rd, prim, wd, be} = {w, !w, p, d, b};
    @(negedge clk);
    got = rdata;
    rsp = {acc_ok, crs, tret};
    {wr, rd} = 2'b00;
  endtask
  task automatic wrc(logic p, logic [31:0] d, logic [3:0] b);
    logic lk;
    lk = mdl[31] & p;
    acc(1'b1, p, d, b);
    chk(rsp, lk ? (dir ? 3'b001 : 3'b010) : 3'b100);
    if (!lk && addr == `BCC_OFF_CHIP_CTRL) mdl = nx(mdl, d, b);
  endtask
  task automatic rdc;
    addr = `BCC_OFF_CHIP_CTRL;
    acc(1'b0, 1'b0, 32'h0, 4'hF);
    chk(got & M, mdl);
    chk(tx_traffic_class, mdl[26] ? mdl[29:27] : 3'h0);
    chk(dt_in_order, mdl[23]);
    chk(loopback_active, mdl[30] & !tz & t1 & t2 & msk & dir);
  endtask
  task automatic rst(logic z, r);
    @(negedge clk);
    {reset_n, tz, dir} = {1'b0, z, r};
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    mdl = {z, 31'h0920_0000};
  endtask
  task automatic tm(int k, int ab, output int c);
    @(negedge clk);
    st[k] = 1'b1;
    @(negedge clk);
    st[k] = 1'b0;
    for (c = 1; c < 1200 && !ex[k]; c++) begin
      @(negedge clk);
      sp[k] = (c == ab);
    end
  endtask
  // ====================
  // timeout
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict;
    end
  end
  // ====================
  // tests
  initial begin
    {clk, reset_n, tz, t1, t2, msk, dir, wr, rd, prim, dd, pl, sl} = '0;
    {st, sp, wd, be, error_cnt, total_checks, fc_cnt, cyc} = '0;
    addr = `BCC_OFF_CHIP_CTRL;
    seed = $urandom(79342);
    rst(1'b1, 1'b0);
    rdc;
    wrc(1'b1, 32'h0, 4'hF);
    wrc(1'b0, 32'h0920_0000, 4'h8);
    repeat (16) begin
      {tz, t1, t2, msk, dd, pl, sl} = 7'($urandom);
      addr = ($urandom_range(3) == 0) ? 8'h44 : `BCC_OFF_CHIP_CTRL;
      wrc(1'($urandom), $urandom, 4'($urandom));
      rdc;
    end
    {dd, pl, sl} = 3'b000;
    $display("test access done");
    wrc(1'b0, 32'h0, 4'hE);
    fc_cnt = 0;
    u_bcc_far_model.credits(6, 0);
    repeat (3) @(negedge clk);
    chkr(fc_cnt, 3, 3);
    wrc(1'b0, 32'h0000_8000, 4'h2);
    fc_cnt = 0;
    u_bcc_far_model.credits(5, $urandom_range(3));
    repeat (3) @(negedge clk);
    chkr(fc_cnt, 5, 5);
    $display("test credits done");
    u_bcc_far_model.retries(300);
    rdc;
    wrc(1'b0, 32'h0002_0000, 4'h4);
    u_bcc_far_model.retries(256);
    mdl[16] = 1'b1;
    rdc;
    wrc(1'b0, 32'h0, 4'h4);
    rdc;
    wrc(1'b0, 32'h0001_0000, 4'h4);
    rdc;
    $display("test retry done");
    wrc(1'b0, 32'h0010_0000, 4'h4);
    tm(0, 0, n);
    chkr(n, 63, 67);
    sl = 1'b1;
    wrc(1'b0, 32'h0, 4'h4);
    tm(0, 0, n);
    chkr(n, 1023, 1027);
    {dd, sl} = 2'b10;
    wrc(1'b0, 32'h0008_0000, 4'h4);
    tm(0, 0, n);
    chkr(n, 1200, 1200);
    $display("test discard done");
    for (int i = 0; i < 4; i++) begin
      wrc(1'b0, {6'h0, i[1:0], 1'b0, i[1:0], 21'h0}, 4'hC);
      tm(1, 0, n);
      chkr(n, 125 * (i + 1) - 1, 125 * (i + 1) + 3);
      tm(2, 0, n);
      chkr(n, 125 * (i + 5) - 1, 125 * (i + 5) + 3);
    end
    tm(2, 20, n);
    chkr(n, 1200, 1200);
    $display("test timers done");
    {t1, t2, msk} = 3'b111;
    rst(1'b0, 1'b1);
    rdc;
    wrc(1'b0, 32'hC000_0000, 4'h8);
    wrc(1'b1, 32'h0, 4'h8);
    rdc;
    $display("test reverse done");
    give_verdict;
  end
endmodule // tb_bcc_chip_ctrl
